//--- verilog/arfc_cfg.svh
`ifndef ARFC_CFG_SVH
`define ARFC_CFG_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ARFC_ADDR_CONFIG 8'h10
`define ARFC_ADDR_STATUS 8'h11
`define ARFC_ADDR_CMP_HIGH 8'h12
`define ARFC_ADDR_CMP_LOW 8'h13
`define ARFC_ADDR_MATCH_LIMIT 8'h14
`define ARFC_ADDR_DIAG 8'h16
`define ARFC_ADDR_RES_HIGH 8'h18
`define ARFC_ADDR_RES_LOW 8'h19

// ****************************************
// field positions
// ****************************************
`define ARFC_CFG_SIGN_BIT 0
`define ARFC_CFG_JUSTIFY_BIT 1
`define ARFC_STAT_READY_BIT 0
`define ARFC_STAT_CMP_BIT 1
`define ARFC_CMPH_EN_BIT 7
`define ARFC_CMPH_MODE_BIT 6
`define ARFC_CMPH_DEC_BIT 5
`define ARFC_CMPH_WR_MASK 8'hE3
`define ARFC_DIAG_WR_MASK 8'h03

// ****************************************
// reset values
// ****************************************
`define ARFC_RST_CONFIG 2'h0
`define ARFC_RST_CMP_HIGH 8'h00
`define ARFC_RST_CMP_LOW 8'h00
`define ARFC_RST_MATCH_LIMIT 8'h00
`define ARFC_RST_DIAG 2'h0
`define ARFC_RST_BYTE 8'h00

`endif

//--- verilog/arfc_pkg.sv
package arfc_pkg;

   // ****************************************
   // carriers
   // ****************************************
   // one finished conversion from the converter core
   typedef struct packed {
      logic done;
      logic [9:0] result;
      logic ratiometric;
   } arfc_conv_t;

   // byte register access from the serial link logic
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } arfc_reg_req_t;

   // formatted byte pair
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } arfc_pair_t;

   // ****************************************
   // shared arithmetic
   // ****************************************
   // signed coding flips the offset-binary midscale bit into two's complement
   function automatic logic [9:0] arfc_code10(input logic [9:0] raw, input logic signed_mode);
      arfc_code10 = signed_mode ? {~raw[9], raw[8:0]} : raw;
   endfunction : arfc_code10

endpackage : arfc_pkg

//--- verilog/arfc_format.sv
`timescale 1ns/1ps
`include "arfc_cfg.svh"

module arfc_format (
   input wire logic core_clk,
   input wire logic reset,
   input wire arfc_pkg::arfc_conv_t conv,
   input wire logic justify_select,
   input wire logic sign_select,
   output arfc_pkg::arfc_pair_t live
);
   import arfc_pkg::*;

   typedef struct packed {
      arfc_pair_t live;
   } arfc_fmt_state_t;

   arfc_fmt_state_t state;
   arfc_fmt_state_t next_state;
   logic signed_mode;
   logic [9:0] coded;

   // absolute and temperature conversions stay unsigned
   assign signed_mode = conv.ratiometric & sign_select;
   assign coded = arfc_code10(conv.result, signed_mode);

   // ****************************************
   // byte split on each finished conversion
   // ****************************************
   always_comb begin
      next_state = state;
      if (conv.done) begin
         if (!justify_select) begin
            next_state.live.high = coded[9:2];
            next_state.live.low = {coded[1:0], 6'h00};
         end else begin
            next_state.live.low = coded[7:0];
            // sign copies fill the unused upper bits
            next_state.live.high = {{6{signed_mode & coded[9]}}, coded[9:8]};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign live = state.live;

endmodule : arfc_format

//--- verilog/arfc_compare.sv
`timescale 1ns/1ps
`include "arfc_cfg.svh"

module arfc_compare (
   input wire logic core_clk,
   input wire logic reset,
   input wire arfc_pkg::arfc_conv_t conv,
   input wire logic enable,
   input wire logic less_mode,
   input wire logic decrement_select,
   input wire logic sign_select,
   input wire logic [9:0] threshold_value,
   input wire logic [7:0] match_count_limit,
   output logic hit
);
   import arfc_pkg::*;

   typedef struct packed {
      logic [7:0] count;
      logic hit;
   } arfc_cmp_state_t;

   arfc_cmp_state_t state;
   arfc_cmp_state_t next_state;
   logic signed_mode;
   logic [9:0] coded;
   logic below;
   logic match;
   logic [7:0] count_up;

   // ****************************************
   // comparison of one result
   // ****************************************
   assign signed_mode = conv.ratiometric & sign_select;
   assign coded = arfc_code10(conv.result, signed_mode);
   assign below = signed_mode ? ($signed(coded) < $signed(threshold_value))
                              : (coded < threshold_value);
   assign match = less_mode ? below : ~below;
   assign count_up = state.count + 8'h01;

   // ****************************************
   // match counter
   // ****************************************
   always_comb begin
      next_state = state;
      next_state.hit = 1'b0;
      if (!enable) begin
         next_state.count = 8'h00;
      end else if (conv.done) begin
         if (match) begin
            // a zero limit means the very first match fires
            if (count_up >= match_count_limit) begin
               next_state.hit = 1'b1;
               next_state.count = 8'h00;
            end else begin
               next_state.count = count_up;
            end
         end else if (decrement_select) begin
            // saturate at zero instead of wrapping
            if (state.count != 8'h00) begin
               next_state.count = state.count - 8'h01;
            end
         end else begin
            next_state.count = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign hit = state.hit;

endmodule : arfc_compare

//--- verilog/arfc_top.sv
`timescale 1ns/1ps
`include "arfc_cfg.svh"

// What this block does
// - a 10-bit result is shown as a high byte and a low byte
// - justify 0: bits 9..2 in high byte, bits 1..0 in low byte
// - left format: high byte read first clears ready and latches low byte
// - justify 1: bits 7..0 in low byte, bits 9..8 in high byte
// - right format: low byte read first clears ready and latches high byte
// - ratiometric results unsigned with sign select 0, signed with 1
// - absolute or temperature results always unsigned
// - right signed format fills unused high bits with the sign
// - each result compared to threshold; a true compare increments the counter
// - false compare decrements counter if decrement select, else clears it
// - counter reaching the match limit sets the comparator flag
// - comparator enable masks the conversion ready flag
// - signed compare only for ratiometric with sign select 1
// - mode 1 true when below threshold; mode 0 true when at or above
// - threshold is control bits 1..0 above the 8 threshold low bits
// - control bits 4..2 always read zero
// - both comparator registers reset to zero, writes ignored while converting
// - zero match limit sets the flag on the first true compare
// - match limit register is read-only while converting
// - diagnostics: bits 1,0 source enables, 6..2 fault flags, 7 zero
// - ready flag set when a formatted result is waiting unread
// - fault flags are live, never latched
module arfc_top (
   input wire logic core_clk,
   input wire logic reset,
   input wire arfc_pkg::arfc_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire arfc_pkg::arfc_conv_t conv,
   input wire logic conv_running,
   input wire logic [3:0] input_fault_flags,
   input wire logic sensor_supply_fault_flag,
   output logic high_source_enable,
   output logic low_source_enable,
   output logic conversion_ready_flag,
   output logic comparator_flag,
   output logic converter_event
);
   import arfc_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [1:0] converter_config;
      logic [7:0] comparator_control_high;
      logic [7:0] comparator_threshold_low;
      logic [7:0] match_count_limit;
      logic [1:0] diag_enables;
      logic ready;
      logic cmp_flag;
      logic [7:0] shadow_high;
      logic [7:0] shadow_low;
      logic [7:0] rdata;
      logic rvalid;
   } arfc_top_state_t;

   arfc_top_state_t state;
   arfc_top_state_t next_state;

   arfc_pair_t live;
   logic cmp_hit;
   logic justify_select;
   logic sign_select;
   logic comparator_enable;
   logic comparison_mode;
   logic decrement_select;
   logic [9:0] threshold_value;
   logic wr_cfg_ok;
   logic rd_high;
   logic rd_low;
   logic first_read;
   logic [7:0] status_byte;
   logic [7:0] diag_byte;
   logic [7:0] cmph_byte;

   // ****************************************
   // field views of the control registers
   // ****************************************
   assign justify_select = state.converter_config[`ARFC_CFG_JUSTIFY_BIT];
   assign sign_select = state.converter_config[`ARFC_CFG_SIGN_BIT];
   assign comparator_enable = state.comparator_control_high[`ARFC_CMPH_EN_BIT];
   assign comparison_mode = state.comparator_control_high[`ARFC_CMPH_MODE_BIT];
   assign decrement_select = state.comparator_control_high[`ARFC_CMPH_DEC_BIT];
   // upper two threshold bits sit in the control register
   assign threshold_value = {state.comparator_control_high[1:0],
                             state.comparator_threshold_low};

   // ****************************************
   // result formatting and comparator
   // ****************************************
   arfc_format u_format (
      .core_clk(core_clk),
      .reset(reset),
      .conv(conv),
      .justify_select(justify_select),
      .sign_select(sign_select),
      .live(live)
   );

   arfc_compare u_compare (
      .core_clk(core_clk),
      .reset(reset),
      .conv(conv),
      .enable(comparator_enable),
      .less_mode(comparison_mode),
      .decrement_select(decrement_select),
      .sign_select(sign_select),
      .threshold_value(threshold_value),
      .match_count_limit(state.match_count_limit),
      .hit(cmp_hit)
   );

   // ****************************************
   // access decode
   // ****************************************
   // comparator register writes are frozen while the converter runs
   assign wr_cfg_ok = reg_req.wr & ~conv_running;
   assign rd_high = reg_req.rd & (reg_req.addr == `ARFC_ADDR_RES_HIGH);
   assign rd_low = reg_req.rd & (reg_req.addr == `ARFC_ADDR_RES_LOW);
   // left format reads the high byte first, right format the low byte first
   assign first_read = justify_select ? rd_low : rd_high;

   // status shows ready only while the comparator leaves it unmasked
   assign status_byte = {6'h00, state.cmp_flag,
                         state.ready & ~comparator_enable};
   // unimplemented control bits forced to zero on read
   assign cmph_byte = state.comparator_control_high & `ARFC_CMPH_WR_MASK;
   // fault flags read straight from the pins, no storage
   assign diag_byte = {1'b0, sensor_supply_fault_flag, input_fault_flags,
                       state.diag_enables};

   // ****************************************
   // register and flag update
   // ****************************************
   always_comb begin
      next_state = state;
      next_state.rvalid = reg_req.rd;

      // software writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            `ARFC_ADDR_CONFIG: begin
               next_state.converter_config = reg_req.wdata[1:0];
            end
            `ARFC_ADDR_CMP_HIGH: begin
               if (wr_cfg_ok) begin
                  next_state.comparator_control_high =
                     reg_req.wdata & `ARFC_CMPH_WR_MASK;
               end
            end
            `ARFC_ADDR_CMP_LOW: begin
               if (wr_cfg_ok) begin
                  next_state.comparator_threshold_low = reg_req.wdata;
               end
            end
            `ARFC_ADDR_MATCH_LIMIT: begin
               if (wr_cfg_ok) begin
                  next_state.match_count_limit = reg_req.wdata;
               end
            end
            `ARFC_ADDR_DIAG: begin
               next_state.diag_enables = reg_req.wdata[1:0];
            end
            default: begin
               next_state.rdata = state.rdata;
            end
         endcase
      end

      // first byte read freezes its partner byte
      if (first_read) begin
         if (justify_select) begin
            next_state.shadow_high = live.high;
         end else begin
            next_state.shadow_low = live.low;
         end
         next_state.ready = 1'b0;
      end

      // comparator flag clears on a status read
      if (reg_req.rd && (reg_req.addr == `ARFC_ADDR_STATUS)) begin
         next_state.cmp_flag = 1'b0;
      end

      // sets placed last so a new event beats a same-cycle clear
      if (conv.done) begin
         next_state.ready = 1'b1;
      end
      if (cmp_hit) begin
         next_state.cmp_flag = 1'b1;
      end

      // read data registered one cycle after the strobe
      if (reg_req.rd) begin
         case (reg_req.addr)
            `ARFC_ADDR_CONFIG: begin
               next_state.rdata = {6'h00, state.converter_config};
            end
            `ARFC_ADDR_STATUS: begin
               next_state.rdata = status_byte;
            end
            `ARFC_ADDR_CMP_HIGH: begin
               next_state.rdata = cmph_byte;
            end
            `ARFC_ADDR_CMP_LOW: begin
               next_state.rdata = state.comparator_threshold_low;
            end
            `ARFC_ADDR_MATCH_LIMIT: begin
               next_state.rdata = state.match_count_limit;
            end
            `ARFC_ADDR_DIAG: begin
               next_state.rdata = diag_byte;
            end
            `ARFC_ADDR_RES_HIGH: begin
               // left format: live byte; right format: frozen partner
               next_state.rdata = justify_select ? state.shadow_high : live.high;
            end
            `ARFC_ADDR_RES_LOW: begin
               next_state.rdata = justify_select ? live.low : state.shadow_low;
            end
            default: begin
               next_state.rdata = `ARFC_RST_BYTE;
            end
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state.converter_config <= `ARFC_RST_CONFIG;
         state.comparator_control_high <= `ARFC_RST_CMP_HIGH;
         state.comparator_threshold_low <= `ARFC_RST_CMP_LOW;
         state.match_count_limit <= `ARFC_RST_MATCH_LIMIT;
         state.diag_enables <= `ARFC_RST_DIAG;
         state.ready <= 1'b0;
         state.cmp_flag <= 1'b0;
         state.shadow_high <= `ARFC_RST_BYTE;
         state.shadow_low <= `ARFC_RST_BYTE;
         state.rdata <= `ARFC_RST_BYTE;
         state.rvalid <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // sources stay under software control; the host must drop them first
   assign high_source_enable = state.diag_enables[1];
   assign low_source_enable = state.diag_enables[0];
   assign conversion_ready_flag = state.ready & ~comparator_enable;
   assign comparator_flag = state.cmp_flag;
   // one summary line for the converter, masked ready or comparator event
   assign converter_event = conversion_ready_flag | state.cmp_flag;
   assign reg_rdata = state.rdata;
   assign reg_rvalid = state.rvalid;

endmodule : arfc_top

//--- verification/arfc_host.sv
`timescale 1ns/1ps

// ****
// host side of the byte register bus
// ****
module arfc_host (
   input wire logic core_clk,
   output arfc_pkg::arfc_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   import arfc_pkg::*;
   initial reg_req = '0;
   // one-cycle write strobe, launched just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge core_clk);
      #1 reg_req.wr = 1'b0;
   endtask : wr
   // a missing answer reads as unknown so it can never match
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1 reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      #1 reg_req.rd = 1'b0;
      d = reg_rvalid ? reg_rdata : 8'hXX;
   endtask : rd
endmodule : arfc_host

//--- verification/arfc_top_chk.sv
`timescale 1ns/1ps
`include "arfc_cfg.svh"

module arfc_top_chk (
   input wire logic core_clk,
   input wire logic reset,
   input wire arfc_pkg::arfc_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire arfc_pkg::arfc_conv_t conv,
   input wire logic conv_running,
   input wire logic [3:0] input_fault_flags,
   input wire logic sensor_supply_fault_flag,
   input wire logic high_source_enable,
   input wire logic low_source_enable,
   input wire logic conversion_ready_flag,
   input wire logic comparator_flag,
   input wire logic converter_event
);
   import arfc_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ****
   // register bus
   // ****
   read_answer_a: assert property (reg_req.rd |=> reg_rvalid)
      else $error("read got no answer");
   answer_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd))
      else $error("answer without read");
   ctl_zero_a: assert property (
      reg_rvalid && $past(reg_req.addr) == `ARFC_ADDR_CMP_HIGH |-> reg_rdata[4:2] == 3'h0)
      else $error("unused control bits set");
   diag_live_a: assert property (
      reg_rvalid && $past(reg_req.addr) == `ARFC_ADDR_DIAG
      |-> reg_rdata[7:2] == {1'b0, $past(sensor_supply_fault_flag), $past(input_fault_flags)})
      else $error("diagnostic flags wrong");
   src_enable_a: assert property (
      reg_req.wr && reg_req.addr == `ARFC_ADDR_DIAG
      |=> {high_source_enable, low_source_enable} == $past(reg_req.wdata[1:0]))
      else $error("source enables wrong");
   // ****
   // flags
   // ****
   event_or_a: assert property (
      converter_event == (conversion_ready_flag | comparator_flag))
      else $error("event not flag union");
   ready_cause_a: assert property (
      $rose(conversion_ready_flag) |-> $past(conv.done)
      || $past(reg_req.wr && reg_req.addr == `ARFC_ADDR_CMP_HIGH))
      else $error("ready without result");
   cmp_cause_a: assert property ($rose(comparator_flag) |-> $past(conv.done, 2))
      else $error("flag without conversion");
   cmp_sticky_a: assert property (
      comparator_flag && !(reg_req.rd && reg_req.addr == `ARFC_ADDR_STATUS)
      |=> comparator_flag)
      else $error("flag dropped");
   cmp_clear_a: assert property (
      comparator_flag && reg_req.rd && !$past(conv.done)
      && reg_req.addr == `ARFC_ADDR_STATUS |=> !comparator_flag)
      else $error("flag not cleared");
   cover property (reg_req.rd && reg_req.addr == `ARFC_ADDR_RES_HIGH);
   cover property ($rose(comparator_flag));
   cover property (conv_running && reg_req.wr);
endmodule : arfc_top_chk

bind arfc_top arfc_top_chk i_chk (.*);

//--- verification/arfc_top_tb.sv
`timescale 1ns/1ps
`include "arfc_cfg.svh"

module arfc_top_tb;
   import arfc_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   arfc_reg_req_t reg_req;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   arfc_conv_t conv = '0;
   logic conv_running = 1'b0;
   logic [3:0] input_fault_flags = 4'h0;
   logic sensor_supply_fault_flag = 1'b0;
   logic high_source_enable;
   logic low_source_enable;
   logic conversion_ready_flag;
   logic comparator_flag;
   logic converter_event;
   int mismatches = 0;
   int tests_run = 0;
   // ctl, threshold low, match limit, sign select, ratiometric
   logic [31:0] cases [4] = '{32'h8140_0001, 32'hE210_0300, 32'h83F0_0203, 32'hA080_0402};
   // free-running clock
   initial forever #20 core_clk = ~core_clk;
   arfc_top i_dut (
      .core_clk(core_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .conv(conv), .conv_running(conv_running),
      .input_fault_flags(input_fault_flags),
      .sensor_supply_fault_flag(sensor_supply_fault_flag),
      .high_source_enable(high_source_enable), .low_source_enable(low_source_enable),
      .conversion_ready_flag(conversion_ready_flag), .comparator_flag(comparator_flag),
      .converter_event(converter_event)
   );
   arfc_host i_host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   // ****
   // helpers
   // ****
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      i_host.rd(a, v);
      chk(v, exp);
   endtask : rdchk
   // returns once the taking edge has landed
   task automatic convert(input logic [9:0] r, input logic ra);
      @(posedge core_clk);
      #1 conv = '{done: 1'b1, result: r, ratiometric: ra};
      @(posedge core_clk);
      #1 conv.done = 1'b0;
   endtask : convert
   // expected {high, low}; signed coding flips the top bit
   function automatic logic [15:0] fmt(input logic [9:0] r, input logic sg, input logic j);
      logic [9:0] c;
      c = sg ? (r ^ 10'h200) : r;
      fmt = j ? {{6{sg & c[9]}}, c} : {c[9:2], c[1:0], 6'h00};
   endfunction : fmt
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   // watchdog, well beyond the thousand or so cycles needed
   initial begin
      #400000;
      mismatches++;
      conclude();
   end
   // ****
   // main sequence
   // ****
   initial begin
      int r, cv, tv, cnt, lim;
      logic [15:0] p;
      logic [15:0] pq [$];
      logic j, s, ra, sg, fl, hit;
      logic [7:0] ctl, fa, sa;
      logic [9:0] th, raw;
      r = $urandom(32'hED076C39);
      repeat (8) @(posedge core_clk);
      #1 reset = 1'b0;
      // reset values, then writes refused while converting
      rdchk(`ARFC_ADDR_CMP_HIGH, 8'h00);
      rdchk(`ARFC_ADDR_CMP_LOW, 8'h00);
      rdchk(`ARFC_ADDR_MATCH_LIMIT, 8'h00);
      conv_running = 1'b1;
      i_host.wr(`ARFC_ADDR_CMP_HIGH, 8'h55);
      i_host.wr(`ARFC_ADDR_CMP_LOW, 8'h66);
      i_host.wr(`ARFC_ADDR_MATCH_LIMIT, 8'h77);
      rdchk(`ARFC_ADDR_CMP_HIGH, 8'h00);
      rdchk(`ARFC_ADDR_CMP_LOW, 8'h00);
      rdchk(`ARFC_ADDR_MATCH_LIMIT, 8'h00);
      // sources only switched on while idle, a running conversion would be spoiled
      conv_running = 1'b0;
      i_host.wr(`ARFC_ADDR_DIAG, 8'hFF);
      chk({6'h00, high_source_enable, low_source_enable}, 8'h03);
      // fault flags follow the pins from read to read
      repeat (3) begin
         input_fault_flags = 4'($urandom);
         sensor_supply_fault_flag = 1'($urandom);
         fa = {1'b0, sensor_supply_fault_flag, input_fault_flags, 2'h3};
         rdchk(`ARFC_ADDR_DIAG, fa);
      end
      i_host.wr(`ARFC_ADDR_DIAG, 8'h00);
      chk({6'h00, high_source_enable, low_source_enable}, 8'h00);
      i_host.wr(`ARFC_ADDR_CMP_HIGH, 8'hFF);
      rdchk(`ARFC_ADDR_CMP_HIGH, 8'hE3);
      i_host.wr(`ARFC_ADDR_CMP_LOW, 8'hA5);
      rdchk(`ARFC_ADDR_CMP_LOW, 8'hA5);
      i_host.wr(`ARFC_ADDR_MATCH_LIMIT, 8'h05);
      rdchk(`ARFC_ADDR_MATCH_LIMIT, 8'h05);
      rdchk(8'h30, 8'h00);
      i_host.wr(`ARFC_ADDR_CMP_HIGH, 8'h00);
      // every format, with a second result landing between the two reads
      for (int k = 0; k < 8; k++) begin
         {j, s, ra} = 3'(k);
         sg = s & ra;
         fa = j ? `ARFC_ADDR_RES_LOW : `ARFC_ADDR_RES_HIGH;
         sa = j ? `ARFC_ADDR_RES_HIGH : `ARFC_ADDR_RES_LOW;
         i_host.wr(`ARFC_ADDR_CONFIG, {6'h00, j, s});
         rdchk(`ARFC_ADDR_CONFIG, {6'h00, j, s});
         chk({7'h00, conversion_ready_flag}, 8'h00);
         repeat (2) begin
            raw = 10'($urandom);
            convert(raw, ra);
            pq.push_back(fmt(raw, sg, j));
            chk({7'h00, conversion_ready_flag}, 8'h01);
            p = pq.pop_front();
            rdchk(fa, j ? p[7:0] : p[15:8]);
            chk({7'h00, conversion_ready_flag}, 8'h00);
            raw = 10'($urandom);
            convert(raw, ra);
            pq.push_back(fmt(raw, sg, j));
            rdchk(sa, j ? p[15:8] : p[7:0]);
            p = pq.pop_front();
            rdchk(fa, j ? p[7:0] : p[15:8]);
         end
      end
      // comparator and match counter against the model
      for (int k = 0; k < 4; k++) begin
         ctl = cases[k][31:24];
         {s, ra} = cases[k][1:0];
         sg = s & ra;
         lim = int'(cases[k][15:8]);
         th = {ctl[1:0], cases[k][23:16]};
         tv = int'(th) - ((sg && th[9]) ? 1024 : 0);
         i_host.wr(`ARFC_ADDR_CONFIG, {7'h00, s});
         i_host.wr(`ARFC_ADDR_CMP_LOW, cases[k][23:16]);
         i_host.wr(`ARFC_ADDR_MATCH_LIMIT, cases[k][15:8]);
         i_host.wr(`ARFC_ADDR_CMP_HIGH, ctl);
         cnt = 0;
         fl = 1'b0;
         repeat (40) begin
            raw = 10'($urandom);
            convert(raw, ra);
            cv = int'(sg ? (raw ^ 10'h200) : raw);
            cv = cv - ((sg && cv >= 512) ? 1024 : 0);
            hit = ctl[6] ? (cv < tv) : (cv >= tv);
            if (hit) begin
               cnt++;
               if (cnt >= lim) begin
                  fl = 1'b1;
                  cnt = 0;
               end
            end else begin
               cnt = ctl[5] ? ((cnt > 0) ? cnt - 1 : 0) : 0;
            end
            @(posedge core_clk);
            #1;
            // summary line must follow the comparator flag while ready is masked
            fa = {5'h00, converter_event, comparator_flag, conversion_ready_flag};
            chk(fa, {5'h00, fl, fl, 1'b0});
            if (fl) begin
               rdchk(`ARFC_ADDR_STATUS, 8'h02);
               fl = 1'b0;
            end
         end
         i_host.wr(`ARFC_ADDR_CMP_HIGH, 8'h00);
      end
      conclude();
   end
endmodule : arfc_top_tb
